// ### rtl/tsi_pkg.sv
// constants shared by the time slot interchange switch
package tsi_pkg;
  // ==========================================================
  // frame geometry
  localparam int STREAMS = 4;
  localparam int CHANNELS = 32;
  localparam int BYTE_W = 8;
  localparam int SW = 2;              // stream index width
  localparam int CH_W = 5;            // channel index width
  localparam int PH_W = 4;            // half-bit phase in a slot
  localparam int CNT_W = CH_W + PH_W; // 512 half-bits per frame
  localparam int DM_AW = SW + CH_W;   // 128 memory positions
  localparam int DM_DEPTH = STREAMS * CHANNELS;
  localparam int SER_CLK_KHZ = 4096;
  localparam int LINE_KBPS = 2048;
  localparam int FRAME_US = 125;
  localparam logic [PH_W-1:0] PH_LAST = 4'hf;
  // ==========================================================
  // control register fields
  localparam logic [BYTE_W-1:0] CTRL_RESET = 8'h00;
  localparam int CTRL_SPLIT = 7;
  localparam int CTRL_FORCE = 6;
  localparam int CTRL_MS_HI = 4;
  localparam int CTRL_MS_LO = 3;
  localparam int CTRL_STREAM_HI = 1;
  localparam int CTRL_STREAM_LO = 0;
  localparam logic [1:0] MS_DATA = 2'h1;
  localparam logic [1:0] MS_LOW = 2'h2;
  localparam logic [1:0] MS_HIGH = 2'h3;
  // ==========================================================
  // host address and connection memory fields
  localparam int HA_W = 6;
  localparam int HA_TOP = 5;
  localparam int CONN_HI_SRC = 2;
  localparam int CONN_HI_OE = 0;
  localparam int CONN_LO_ST_HI = 6;
  localparam int CONN_LO_CH_LO = 0;
  // stored high byte keeps only source and enable bits
  localparam int CONN_HI_SRC_IDX = 1;
  localparam int CONN_HI_OE_IDX = 0;
endpackage

// ### rtl/tsi_frame_if.sv
// slot timing carried from the frame timer to the switch core
`timescale 1ns/100ps
interface tsi_frame_if;
  import tsi_pkg::*;
  logic            tick;
  logic [PH_W-1:0] phase;
  logic [CH_W-1:0] chan;
  modport timer (output tick, phase, chan);
  modport core  (input tick, phase, chan);
endinterface

// ### rtl/tsi_frame_timer.sv
// serial clock edge detect and frame/channel/bit counter
`timescale 1ns/100ps
module tsi_frame_timer (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // frame pins
  input  wire logic serial_clock_n,
  input  wire logic frame_pulse_n,
  // slot timing
  tsi_frame_if.timer frame
);
  import tsi_pkg::*;

  logic [1:0]       sclk_sync_reg, sclk_sync_next;
  logic [1:0]       fp_sync_reg, fp_sync_next;
  logic             sclk_prev_reg, sclk_prev_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic             tick;

  // ==========================================================
  // counter: one tick per serial clock period
  always_comb begin
    sclk_sync_next = {sclk_sync_reg[0], serial_clock_n};
    fp_sync_next = {fp_sync_reg[0], frame_pulse_n};
    sclk_prev_next = sclk_sync_reg[1];
    tick = ce & sclk_sync_reg[1] & ~sclk_prev_reg;
    cnt_next = cnt_reg;
    if (tick) begin
      // frame pulse low restarts channel and bit count
      if (!fp_sync_reg[1]) begin
        cnt_next = '0;
      end else begin
        cnt_next = cnt_reg + 1'b1; // wraps every 125 us
      end
    end
  end

  // registers only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_sync_reg <= '0;
      fp_sync_reg <= 2'h3;
      sclk_prev_reg <= 1'b0;
      cnt_reg <= '0;
    end else if (ce) begin
      sclk_sync_reg <= sclk_sync_next;
      fp_sync_reg <= fp_sync_next;
      sclk_prev_reg <= sclk_prev_next;
      cnt_reg <= cnt_next;
    end
  end

  assign frame.tick = tick;
  assign frame.phase = cnt_reg[PH_W-1:0];
  assign frame.chan = cnt_reg[CNT_W-1:PH_W];

  // ==========================================================
  // checks
  property p_frame_clear;
    @(posedge clk) disable iff (!rst_n)
    tick && !fp_sync_reg[1] |=> cnt_reg == '0;
  endproperty
  a_frame_clear: assert property (p_frame_clear)
    else $error("counter not cleared by frame pulse");

  c_frame: cover property (@(posedge clk) disable iff (!rst_n)
    tick && !fp_sync_reg[1]);
endmodule // tsi_frame_timer

// ### rtl/tsi_switch.sv
// time slot interchange switch core with host port
`timescale 1ns/100ps

// Function
// - streams run 2.048 Mb/s, 125 us frames of 32 byte channels
// - four in and four out streams, any of 128 to any of 128
// - one external 4.096 MHz serial clock shifts every stream
// - each received byte is written in turn into a 128 byte memory
// - low frame pulse clears the channel and bit counter
// - open-drain low acknowledge marks the end of a host transfer
// - access happens only with select low and strobe high
// - host drives read/write; device drives data only on reads
// - master enable low floats every serial output
// - reset clears counters, registers, floats serial and data outputs
// - every output channel owns a 16 bit connection entry
// - processor mode sends the channel's low connection byte
// - processor mode repeats that byte each frame until rewritten
// - connection mode sends the data memory byte the low byte names
// - many outputs may name one input, broadcasting it
// - output byte fetched in the preceding slot, then loaded
// - data never leaves in its arrival slot; same slot is next frame
// - high connection byte picks mode and driver enable per channel
// - top address low reaches control, high picks one of 32 channels
// - stream field plus channel lines pick the memory position
// - split mode reads data memory, writes selected connection half
// - memory select 01 data, 10 low half, 11 high half, 00 none
// - high byte bit 2 picks processor mode, bit 0 enables driver
// - force bit makes all channels processor mode and enabled
// - two-slot delay only from in 0 to out 1-3, in 1 to out 3
module tsi_switch (
  // clock and reset
  input  wire logic                        REF_CLK,
  input  wire logic                        RESET_N,
  input  wire logic                        CLK_EN,
  // frame pins
  input  wire logic                        SERIAL_CLOCK_N,
  input  wire logic                        FRAME_PULSE_N,
  // serial streams
  input  wire logic [tsi_pkg::STREAMS-1:0] SERIAL_IN,
  output logic      [tsi_pkg::STREAMS-1:0] SERIAL_OUT,
  output logic      [tsi_pkg::STREAMS-1:0] SERIAL_OUT_OE,
  input  wire logic                        SERIAL_OUT_MASTER_ENABLE,
  // host port
  input  wire logic [tsi_pkg::HA_W-1:0]    HOST_ADDR,
  input  wire logic                        CHIP_SELECT_N,
  input  wire logic                        BUS_STROBE,
  input  wire logic                        HOST_RW,
  input  wire logic [tsi_pkg::BYTE_W-1:0]  HOST_DATA_IN,
  output logic      [tsi_pkg::BYTE_W-1:0]  HOST_DATA_OUT,
  output logic                             HOST_DATA_OE,
  output logic                             TRANSFER_ACK_N_OUT,
  output logic                             TRANSFER_ACK_N_OE
);
  import tsi_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DONE = 2'b10
  } tsi_bus_state_type;

  typedef logic [STREAMS-1:0][BYTE_W-1:0] tsi_bytes_type;

  // memory position of a stream and channel
  function automatic logic [DM_AW-1:0] dm_addr(input logic [SW-1:0] st,
                                               input logic [CH_W-1:0] ch);
    dm_addr = {st, ch};
  endfunction

  // ==========================================================
  // slot timing
  tsi_frame_if frame ();

  tsi_frame_timer u_timer (
    .clk            (REF_CLK),
    .rst_n          (RESET_N),
    .ce             (CLK_EN),
    .serial_clock_n (SERIAL_CLOCK_N),
    .frame_pulse_n  (FRAME_PULSE_N),
    .frame          (frame)
  );

  // ==========================================================
  // pin synchronisers
  logic [1:0][STREAMS-1:0] rx_sync_reg;
  logic [1:0]              mst_sync_reg;
  logic [1:0][HA_W-1:0]    addr_sync_reg;
  logic [1:0][BYTE_W-1:0]  din_sync_reg;
  logic [1:0]              sel_sync_reg, stb_sync_reg, rw_sync_reg;
  logic                    master_s, sel_s, stb_s, rw_s;
  logic [HA_W-1:0]         addr_s;
  logic [BYTE_W-1:0]       din_s;

  assign master_s = mst_sync_reg[1];
  assign sel_s = sel_sync_reg[1];
  assign stb_s = stb_sync_reg[1];
  assign rw_s = rw_sync_reg[1];
  assign addr_s = addr_sync_reg[1];
  assign din_s = din_sync_reg[1];

  // two stages for every asynchronous pin
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rx_sync_reg <= '0;
      mst_sync_reg <= '0;
      addr_sync_reg <= '0;
      din_sync_reg <= '0;
      sel_sync_reg <= 2'h3;
      stb_sync_reg <= '0;
      rw_sync_reg <= '0;
    end else if (CLK_EN) begin
      rx_sync_reg <= {rx_sync_reg[0], SERIAL_IN};
      mst_sync_reg <= {mst_sync_reg[0], SERIAL_OUT_MASTER_ENABLE};
      addr_sync_reg <= {addr_sync_reg[0], HOST_ADDR};
      din_sync_reg <= {din_sync_reg[0], HOST_DATA_IN};
      sel_sync_reg <= {sel_sync_reg[0], CHIP_SELECT_N};
      stb_sync_reg <= {stb_sync_reg[0], BUS_STROBE};
      rw_sync_reg <= {rw_sync_reg[0], HOST_RW};
    end
  end

  // ==========================================================
  // memories: data, connection low and high (source, enable)
  logic [BYTE_W-1:0] dmem [DM_DEPTH];
  logic [BYTE_W-1:0] conn_mem_low [DM_DEPTH];
  logic [1:0]        conn_mem_high [DM_DEPTH];
  logic [BYTE_W-1:0] ctrl_reg, ctrl_next;
  logic              force_all;
  logic [1:0]        ms_field;
  logic [SW-1:0]     stream_select_field;

  assign force_all = ctrl_reg[CTRL_FORCE];
  assign ms_field = ctrl_reg[CTRL_MS_HI:CTRL_MS_LO];
  assign stream_select_field = ctrl_reg[CTRL_STREAM_HI:CTRL_STREAM_LO];

  // ==========================================================
  // serial path
  tsi_bytes_type      rx_sh_reg, rx_sh_next, rx_hold_reg, rx_hold_next;
  tsi_bytes_type      tx_sh_reg, tx_sh_next, fetch_reg, fetch_next;
  logic [STREAMS-1:0] tx_en_reg, tx_en_next, fen_reg, fen_next;
  logic [STREAMS-1:0] tx_oe_reg, tx_oe_next;
  logic [CH_W-1:0]    hold_ch_reg, hold_ch_next, nxt_ch;
  logic               dm_we;
  logic [DM_AW-1:0]   dm_waddr, f_idx;
  logic [BYTE_W-1:0]  dm_wdata;

  // writes for stream s land at phase 2s and fetches for out stream t at
  // phase t of the slot, so only the listed stream pairs get 2 slots delay
  always_comb begin
    rx_sh_next = rx_sh_reg;
    rx_hold_next = rx_hold_reg;
    hold_ch_next = hold_ch_reg;
    tx_sh_next = tx_sh_reg;
    tx_en_next = tx_en_reg;
    fetch_next = fetch_reg;
    fen_next = fen_reg;
    dm_we = 1'b0;
    dm_waddr = '0;
    dm_wdata = '0;
    f_idx = '0;
    nxt_ch = frame.chan + 1'b1;
    if (frame.tick) begin
      if (frame.phase == PH_LAST) begin
        hold_ch_next = frame.chan;
      end
      for (int s = 0; s < STREAMS; s++) begin
        // sample mid-bit, msb first
        if (!frame.phase[0]) begin
          rx_sh_next[s] = {rx_sh_reg[s][BYTE_W-2:0], rx_sync_reg[1][s]};
        end
        if (frame.phase == PH_LAST) begin
          rx_hold_next[s] = rx_sh_reg[s];
        end
        // staggered write of the previous slot's byte
        if (frame.phase == PH_W'(2 * s)) begin
          dm_we = 1'b1;
          dm_waddr = dm_addr(SW'(s), hold_ch_reg);
          dm_wdata = rx_hold_reg[s];
        end
        // fetch next channel's byte one slot early
        if (frame.phase == PH_W'(s)) begin
          f_idx = dm_addr(SW'(s), nxt_ch);
          // force bit overrides mode and enable
          fen_next[s] = force_all | conn_mem_high[f_idx][CONN_HI_OE_IDX];
          if (force_all | conn_mem_high[f_idx][CONN_HI_SRC_IDX]) begin
            fetch_next[s] = conn_mem_low[f_idx];
          end else begin
            // low byte is the source address
            fetch_next[s] = dmem[conn_mem_low[f_idx][CONN_LO_ST_HI:CONN_LO_CH_LO]];
          end
        end
        // load at slot end, shift at each bit end
        if (frame.phase == PH_LAST) begin
          tx_sh_next[s] = fetch_reg[s];
          tx_en_next[s] = fen_reg[s];
        end else if (frame.phase[0]) begin
          tx_sh_next[s] = {tx_sh_reg[s][BYTE_W-2:0], 1'b0};
        end
      end
    end
    // master enable gates every channel driver
    tx_oe_next = master_s ? tx_en_next : '0;
  end

  // registers only; reset floats the outputs
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rx_sh_reg <= '0;
      rx_hold_reg <= '0;
      hold_ch_reg <= '0;
      tx_sh_reg <= '0;
      tx_en_reg <= '0;
      fetch_reg <= '0;
      fen_reg <= '0;
      tx_oe_reg <= '0;
    end else if (CLK_EN) begin
      rx_sh_reg <= rx_sh_next;
      rx_hold_reg <= rx_hold_next;
      hold_ch_reg <= hold_ch_next;
      tx_sh_reg <= tx_sh_next;
      tx_en_reg <= tx_en_next;
      fetch_reg <= fetch_next;
      fen_reg <= fen_next;
      tx_oe_reg <= tx_oe_next;
    end
  end

  // serial outputs straight from flops
  always_comb begin
    for (int s = 0; s < STREAMS; s++) begin
      SERIAL_OUT[s] = tx_sh_reg[s][BYTE_W-1];
    end
  end
  assign SERIAL_OUT_OE = tx_oe_reg;

  // ==========================================================
  // host port
  tsi_bus_state_type state_reg, state_next;
  logic [BYTE_W-1:0] rd_reg, rd_next;
  logic              doe_reg, doe_next, ack_reg, ack_next;
  logic              go, conn_low_we, conn_high_we;
  logic [DM_AW-1:0]  h_idx;

  // select low and strobe high together open one access
  always_comb begin
    go = (state_reg == ST_IDLE) && !sel_s && stb_s;
    h_idx = dm_addr(stream_select_field, addr_s[CH_W-1:0]);
    state_next = state_reg;
    ctrl_next = ctrl_reg;
    rd_next = rd_reg;
    conn_low_we = 1'b0;
    conn_high_we = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (go) begin
          state_next = ST_DONE;
          rd_next = '0;
          if (!addr_s[HA_TOP]) begin
            // control register at any low address
            if (rw_s) begin
              rd_next = ctrl_reg;
            end else begin
              ctrl_next = din_s;
            end
          end else if (rw_s) begin
            // split mode always reads data memory
            if (ctrl_reg[CTRL_SPLIT] || ms_field == MS_DATA) begin
              rd_next = dmem[h_idx];
            end else if (ms_field == MS_LOW) begin
              rd_next = conn_mem_low[h_idx];
            end else if (ms_field == MS_HIGH) begin
              rd_next[CONN_HI_SRC] = conn_mem_high[h_idx][CONN_HI_SRC_IDX];
              rd_next[CONN_HI_OE] = conn_mem_high[h_idx][CONN_HI_OE_IDX];
            end
          end else begin
            // data memory is read-only; code 00 writes nothing
            conn_low_we = (ms_field == MS_LOW);
            conn_high_we = (ms_field == MS_HIGH);
          end
        end
      end
      ST_DONE: begin
        // hold the acknowledge until the strobe or select drops
        if (sel_s || !stb_s) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    ack_next = (state_next == ST_DONE);
    doe_next = (state_next == ST_DONE) && rw_s;
  end

  // registers only
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= ST_IDLE;
      ctrl_reg <= CTRL_RESET;
      rd_reg <= '0;
      doe_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else if (CLK_EN) begin
      state_reg <= state_next;
      ctrl_reg <= ctrl_next;
      rd_reg <= rd_next;
      doe_reg <= doe_next;
      ack_reg <= ack_next;
    end
  end

  // memory write ports; contents are not cleared by reset
  always_ff @(posedge REF_CLK) begin
    if (CLK_EN && dm_we) begin
      dmem[dm_waddr] <= dm_wdata;
    end
    if (CLK_EN && conn_low_we) begin
      conn_mem_low[h_idx] <= din_s;
    end
    if (CLK_EN && conn_high_we) begin
      conn_mem_high[h_idx] <= {din_s[CONN_HI_SRC], din_s[CONN_HI_OE]};
    end
  end

  // open drain: only ever pulled low
  assign TRANSFER_ACK_N_OUT = 1'b0;
  assign TRANSFER_ACK_N_OE = ack_reg;
  assign HOST_DATA_OUT = rd_reg;
  assign HOST_DATA_OE = doe_reg;

  // ==========================================================
  // checks
  property p_master_off;
    @(posedge REF_CLK) disable iff (!RESET_N)
    CLK_EN && !master_s |=> SERIAL_OUT_OE == '0;
  endproperty
  a_master_off: assert property (p_master_off)
    else $error("serial driver on while master enable low");

  property p_ack_start;
    @(posedge REF_CLK) disable iff (!RESET_N)
    CLK_EN && go |=> TRANSFER_ACK_N_OE && !TRANSFER_ACK_N_OUT;
  endproperty
  a_ack_start: assert property (p_ack_start)
    else $error("no acknowledge after access");

  property p_ack_cause;
    @(posedge REF_CLK) disable iff (!RESET_N)
    $rose(TRANSFER_ACK_N_OE) |-> !$past(sel_s) && $past(stb_s);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("acknowledge without select and strobe");

  property p_data_read;
    @(posedge REF_CLK) disable iff (!RESET_N)
    HOST_DATA_OE |-> TRANSFER_ACK_N_OE && $past(rw_s);
  endproperty
  a_data_read: assert property (p_data_read)
    else $error("data driven outside a read");

  property p_ctrl_write;
    @(posedge REF_CLK) disable iff (!RESET_N)
    CLK_EN && go && !rw_s && !addr_s[HA_TOP] |=> ctrl_reg == $past(din_s);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control register write lost");

  property p_force_en;
    @(posedge REF_CLK) disable iff (!RESET_N)
    CLK_EN && frame.tick && frame.phase == '0 && force_all |=> fen_reg[0];
  endproperty
  a_force_en: assert property (p_force_en)
    else $error("force bit did not enable channel");

  property p_load;
    @(posedge REF_CLK) disable iff (!RESET_N)
    CLK_EN && frame.tick && frame.phase == PH_LAST
      |=> tx_sh_reg === $past(fetch_reg) && tx_en_reg === $past(fen_reg);
  endproperty
  a_load: assert property (p_load)
    else $error("fetched byte not loaded at slot start");

  property p_oe_follows;
    @(posedge REF_CLK) disable iff (!RESET_N)
    CLK_EN && master_s |=> SERIAL_OUT_OE === $past(tx_en_next);
  endproperty
  a_oe_follows: assert property (p_oe_follows)
    else $error("driver enable does not follow channel setting");

  c_read: cover property (@(posedge REF_CLK) disable iff (!RESET_N)
    HOST_DATA_OE);
  c_force: cover property (@(posedge REF_CLK) disable iff (!RESET_N)
    force_all && SERIAL_OUT_OE != '0);
  c_low_wr: cover property (@(posedge REF_CLK) disable iff (!RESET_N)
    conn_low_we);
endmodule // tsi_switch

// ### sim/tsi_stream_partner.sv
// far-side model: serial clock, frame pulse, input streams, output capture
`timescale 1ns/100ps
module tsi_stream_partner #(
  parameter int HALF_NS = 16
) (
  // frame pins
  output logic       serial_clock_n,
  output logic       frame_pulse_n,
  // serial streams
  output logic [3:0] serial_in,
  input  wire logic [3:0] serial_out,
  input  wire logic [3:0] serial_out_oe
);
  // ==========================================================
  // state
  logic [8:0] pos;
  int         frames;
  logic [7:0] src;
  logic [7:0] shift [4];
  logic [7:0] rx_byte [4][32];
  logic       oe_seen [4][32];
  // free-running clock, faster than the line rate to keep frames short
  initial begin
    serial_clock_n = 1'b0;
    forever #(HALF_NS) serial_clock_n = ~serial_clock_n;
  end
  // each bit spans two ticks; 16 ticks a slot, 32 slots a frame
  initial begin
    pos = 9'h1ff;
    frames = 0;
    frame_pulse_n = 1'b1;
    serial_in = 4'h0;
    forever begin
      @(posedge serial_clock_n);
      #1;
      pos = pos + 9'h001;
      if (pos == 9'h000) frames++;
      frame_pulse_n = (pos != 9'h1ff); // low across the last tick of each frame
      for (int s = 0; s < 4; s++) begin
        src = {s[1:0], pos[8:4], 1'b1};
        serial_in[s] = src[3'h7 - pos[3:1]]; // msb first
      end
    end
  end
  // the switch moves its output a few ns after each odd tick, so the
  // falling edge of the even tick is the middle of the bit
  always @(negedge serial_clock_n) begin
    if (!pos[0]) begin
      for (int s = 0; s < 4; s++) begin
        shift[s] = {shift[s][6:0], serial_out[s]};
        if (pos[3:0] == 4'he) begin
          rx_byte[s][pos[8:4]] = shift[s];
          oe_seen[s][pos[8:4]] = serial_out_oe[s];
        end
      end
    end
  end
endmodule // tsi_stream_partner

// ### sim/test_tsi_switch.sv
// self-checking bench for the time slot interchange switch
`timescale 1ns/100ps
module test_tsi_switch;
  import tsi_pkg::*;
  // ==========================================================
  // pins and counters
  logic       ref_clk, reset_n, master_en, sel_n, strobe, rw;
  logic [5:0] addr;
  logic [7:0] wdata, rdata;
  logic       data_oe, ack_out, ack_oe, ser_clk_n, frame_n;
  logic [3:0] ser_in, ser_out, ser_oe;
  wire        ack_line = ack_oe ? ack_out : 1'b1; // pull-up when released
  int         err_total, num_checks;
  // ==========================================================
  // design and far side
  tsi_switch u_dut (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .CLK_EN(1'b1),
    .SERIAL_CLOCK_N(ser_clk_n), .FRAME_PULSE_N(frame_n),
    .SERIAL_IN(ser_in), .SERIAL_OUT(ser_out), .SERIAL_OUT_OE(ser_oe),
    .SERIAL_OUT_MASTER_ENABLE(master_en),
    .HOST_ADDR(addr), .CHIP_SELECT_N(sel_n), .BUS_STROBE(strobe),
    .HOST_RW(rw), .HOST_DATA_IN(wdata), .HOST_DATA_OUT(rdata),
    .HOST_DATA_OE(data_oe), .TRANSFER_ACK_N_OUT(ack_out),
    .TRANSFER_ACK_N_OE(ack_oe)
  );
  tsi_stream_partner u_partner (
    .serial_clock_n(ser_clk_n), .frame_pulse_n(frame_n), .serial_in(ser_in),
    .serial_out(ser_out), .serial_out_oe(ser_oe)
  );
  // ==========================================================
  // compare and closing tasks
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    chk8(n, {7'h00, e}, {7'h00, g});
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================================
  // host port: hold everything until the acknowledge is sampled low
  task automatic host(input logic r, input logic [5:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic oe);
    int k;
    k = 0;
    @(posedge ref_clk);
    #1;
    {rw, addr, wdata, sel_n, strobe} = {r, a, d, 2'b01};
    @(posedge ref_clk);
    #1;
    // look just after each edge, once the registered acknowledge has settled
    while (ack_line !== 1'b0 && k < 40) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    chk1("transfer ack", 1'b0, ack_line);
    q = rdata;
    oe = data_oe;
    {sel_n, strobe} = 2'b10;
    k = 0;
    while (ack_line !== 1'b1 && k < 40) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    chk1("transfer ack release", 1'b1, ack_line);
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       oe;
    host(1'b0, a, d, q, oe);
    chk1("data drive on write", 1'b0, oe);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic       oe;
    host(1'b1, a, 8'h00, q, oe);
    chk1("data drive on read", 1'b1, oe);
    chk8("read data", e, q);
  endtask
  task automatic ctl(input logic sp, input logic fo, input logic [1:0] ms, input logic [1:0] st);
    wr(6'h00, {sp, fo, 1'b0, ms, 1'b0, st});
  endtask
  task automatic set_chan(input logic [1:0] s, input logic [4:0] c, input logic [7:0] hi,
                          input logic [7:0] lo);
    ctl(1'b0, 1'b0, MS_LOW, s);
    wr({1'b1, c}, lo);
    ctl(1'b0, 1'b0, MS_HIGH, s);
    wr({1'b1, c}, hi);
  endtask
  task automatic frames(input int n);
    int t;
    int k;
    // one spare frame: a byte fetched just before the last write may be queued
    t = u_partner.frames + n + 1;
    k = 0;
    while (u_partner.frames < t && k < 5000 * (n + 1)) begin
      @(posedge ref_clk);
      k++;
    end
    chk1("frame progress", 1'b1, u_partner.frames >= t);
  endtask
  task automatic chk_out(input int s, input int c, input logic [7:0] e, input logic o);
    chk8("serial byte", e, u_partner.rx_byte[s][c]);
    chk1("serial enable", o, u_partner.oe_seen[s][c]);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    rdc(6'h00, CTRL_RESET);
    ctl(1'b0, 1'b1, MS_HIGH, 2'h3);
    rdc(6'h1f, 8'h5b);
    ctl(1'b0, 1'b0, MS_DATA, 2'h0);
    $display("test regs done");
  endtask
  task automatic t_proc();
    set_chan(2'h1, 5'h00, 8'h05, 8'h3c);
    set_chan(2'h1, 5'h1f, 8'h05, 8'hc3);
    set_chan(2'h2, 5'h05, 8'h00, 8'h11);
    frames(2);
    chk_out(1, 0, 8'h3c, 1'b1);
    chk_out(1, 31, 8'hc3, 1'b1);
    chk1("disabled channel", 1'b0, u_partner.oe_seen[2][5]);
    set_chan(2'h1, 5'h00, 8'h05, 8'h5a);
    frames(2);
    chk_out(1, 0, 8'h5a, 1'b1);
    rdc(6'h20, 8'h05);
    $display("test processor mode done");
  endtask
  task automatic t_conn();
    set_chan(2'h3, 5'h07, 8'h01, 8'h53);
    set_chan(2'h0, 5'h09, 8'h01, 8'h53);
    set_chan(2'h2, 5'h00, 8'h01, 8'h00);
    frames(2);
    chk_out(3, 7, 8'ha7, 1'b1);
    chk_out(0, 9, 8'ha7, 1'b1);
    chk_out(2, 0, 8'h01, 1'b1);
    $display("test connection mode done");
  endtask
  task automatic t_mem();
    ctl(1'b0, 1'b0, MS_DATA, 2'h2);
    rdc(6'h33, 8'ha7);
    wr(6'h33, 8'h00);
    rdc(6'h33, 8'ha7);
    ctl(1'b0, 1'b0, 2'h0, 2'h2);
    rdc(6'h33, 8'h00);
    ctl(1'b1, 1'b0, MS_LOW, 2'h1);
    rdc(6'h23, 8'h47);
    wr(6'h20, 8'h77);
    frames(2);
    chk_out(1, 0, 8'h77, 1'b1);
    $display("test memory access done");
  endtask
  task automatic t_force();
    logic seen;
    ctl(1'b0, 1'b1, MS_LOW, 2'h0);
    frames(2);
    chk_out(2, 5, 8'h11, 1'b1);
    #1;
    master_en = 1'b0;
    repeat (8) @(posedge ref_clk);
    seen = 1'b0;
    repeat (4200) begin
      @(posedge ref_clk);
      if (ser_oe !== 4'h0) seen = 1'b1;
    end
    chk1("outputs float", 1'b0, seen);
    #1;
    master_en = 1'b1;
    $display("test force and master enable done");
  endtask
  // ==========================================================
  // clock, watchdog and main sequence
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    #360000; // about 90k cycles, well past what the tests need
    err_total++;
    $display("FAIL watchdog expected done seen hang");
    end_sim();
  end
  initial begin
    {err_total, num_checks} = 0;
    {reset_n, master_en, sel_n, strobe, rw, addr, wdata} = {3'b011, 2'b00, 6'h00, 8'h00};
    repeat (26) @(posedge ref_clk); // over 100 ns
    chk1("ack float in reset", 1'b0, ack_oe);
    chk1("data float in reset", 1'b0, data_oe);
    chk8("serial float in reset", 8'h00, {4'h0, ser_oe});
    #1;
    reset_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    t_regs();
    t_proc();
    t_conn();
    t_mem();
    t_force();
    end_sim();
  end
endmodule // test_tsi_switch
